//--- bro_map.vh
// named constants shared by the biphase receiver output block
`ifndef BRO_MAP_VH
`define BRO_MAP_VH

// ----------------------------------------------------------------
// rate estimate codes, upper bit first
// ----------------------------------------------------------------
`define BRO_RATE_LL 2'h0
`define BRO_RATE_LH 2'h1
`define BRO_RATE_HL 2'h2
`define BRO_RATE_HH 2'h3

// ----------------------------------------------------------------
// reference clock and rate windows, in hertz
// ----------------------------------------------------------------
`define BRO_REF_HZ 32'h0177_0000
`define BRO_F32_LO_HZ 32'h0000_79E0
`define BRO_F32_HI_HZ 32'h0000_8020
`define BRO_F44_LO_HZ 32'h0000_A7F8
`define BRO_F44_HI_HZ 32'h0000_B090
`define BRO_F48_LO_HZ 32'h0000_B6D0
`define BRO_F48_HI_HZ 32'h0000_C030

// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
`define BRO_REF_TIMEOUT 16'h0040
`define BRO_RATE_JUMP_TOL 12'h010
`define BRO_CNT_MAX 12'hFFF
`define BRO_XTI_BCK_HALF 2'h2
`define BRO_PRIME_EDGES 2'h3

// ----------------------------------------------------------------
// serial formats and slot layout
// ----------------------------------------------------------------
`define BRO_FMT_RJ16 2'h0
`define BRO_FMT_RJ24 2'h1
`define BRO_FMT_LJ24 2'h2
`define BRO_FMT_I2S24 2'h3
`define BRO_START_RJ16 5'h10
`define BRO_START_RJ24 5'h08
`define BRO_START_LJ24 5'h00
`define BRO_START_I2S24 5'h01
`define BRO_WIDTH_16 5'h10
`define BRO_WIDTH_24 5'h18
`define BRO_MSB_INDEX 5'h17
`define BRO_LAST_SLOT 6'h3F

`endif

//--- bro_rate_est.v
// sampling rate estimator measured against the reference clock
`timescale 1ns/1ns
`include "bro_map.vh"
module bro_rate_est #(
  parameter TIMEOUT = `BRO_REF_TIMEOUT
) (
  input wire sys_clk_i,
  input wire reset_i,
  input wire ce_i,
  input wire ref_edge_i,
  input wire frame_tick_i,
  input wire locked_i,
  output reg [1:0] rate_code_o,
  output reg rate_jump_o
);
  localparam integer C32_LO = (`BRO_REF_HZ + `BRO_F32_HI_HZ - 1) / `BRO_F32_HI_HZ;
  localparam integer C32_HI = `BRO_REF_HZ / `BRO_F32_LO_HZ;
  localparam integer C44_LO = (`BRO_REF_HZ + `BRO_F44_HI_HZ - 1) / `BRO_F44_HI_HZ;
  localparam integer C44_HI = `BRO_REF_HZ / `BRO_F44_LO_HZ;
  localparam integer C48_LO = (`BRO_REF_HZ + `BRO_F48_HI_HZ - 1) / `BRO_F48_HI_HZ;
  localparam integer C48_HI = `BRO_REF_HZ / `BRO_F48_LO_HZ;

  reg [11:0] cnt;
  reg [11:0] last;
  reg have_last;
  reg ref_seen;
  reg ref_alive;
  reg [15:0] idle;
  reg [1:0] class_code;
  wire [11:0] diff = (cnt > last) ? (cnt - last) : (last - cnt);

  // reference edges per frame map onto a rate window
  function [1:0] classify;
    input [11:0] c;
    begin
      if (c >= C32_LO[11:0] && c <= C32_HI[11:0])
        classify = `BRO_RATE_HH; // see [R8]
      else if (c >= C44_LO[11:0] && c <= C44_HI[11:0])
        classify = `BRO_RATE_LL; // see [R8]
      else if (c >= C48_LO[11:0] && c <= C48_HI[11:0])
        classify = `BRO_RATE_LH; // see [R8]
      else
        classify = `BRO_RATE_HL; // see [R5]
    end
  endfunction

  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt <= 12'h000;
      last <= 12'h000;
      have_last <= 1'b0;
      ref_seen <= 1'b0;
      ref_alive <= 1'b0;
      idle <= 16'h0000;
      class_code <= `BRO_RATE_HL;
      rate_code_o <= `BRO_RATE_LL;
      rate_jump_o <= 1'b0;
    end else if (ce_i) begin
      if (ref_edge_i) begin
        idle <= 16'h0000;
        ref_alive <= 1'b1;
        ref_seen <= 1'b1;
      end else if (idle == TIMEOUT) begin
        ref_alive <= 1'b0; // see [R7]
      end else begin
        idle <= idle + 16'h0001;
      end
      if (frame_tick_i) begin
        cnt <= {11'h000, ref_edge_i};
        // a stopped reference freezes the last result
        if (ref_alive) begin // see [R7]
          class_code <= classify(cnt);
          last <= cnt;
          have_last <= 1'b1;
          rate_jump_o <= have_last && (diff > `BRO_RATE_JUMP_TOL); // see [R3]
        end
      end else if (ref_edge_i && cnt != `BRO_CNT_MAX) begin
        cnt <= cnt + 12'h001;
      end
      if (!ref_seen)
        rate_code_o <= `BRO_RATE_LL; // see [R6] [R4]
      else if (!locked_i)
        rate_code_o <= `BRO_RATE_HL; // see [R5] [R9]
      else
        rate_code_o <= class_code;
    end
  end
endmodule

//--- bro_serializer.v
// serial audio shifter for the four justified formats
`timescale 1ns/1ns
`include "bro_map.vh"
module bro_serializer (
  input wire sys_clk_i,
  input wire reset_i,
  input wire ce_i,
  input wire bit_tick_i,
  input wire [1:0] fmt_i,
  input wire [23:0] left_i,
  input wire [23:0] right_i,
  output reg word_clock_o,
  output reg data_o
);
  reg [5:0] cnt;
  reg [23:0] cur_l;
  reg [23:0] cur_r;
  wire [5:0] ncnt = cnt + 6'h01;
  wire load = (cnt == `BRO_LAST_SLOT);
  wire [23:0] nl = load ? left_i : cur_l;
  wire [23:0] nr = load ? right_i : cur_r;
  wire [23:0] word = ncnt[5] ? nr : nl;
  wire [4:0] pos = ncnt[4:0];
  wire [4:0] start = slot_start(fmt_i);
  wire [4:0] off = pos - start;
  wire [4:0] width = (fmt_i == `BRO_FMT_RJ16) ? `BRO_WIDTH_16 : `BRO_WIDTH_24;
  wire [4:0] idx = `BRO_MSB_INDEX - off;
  wire in_word = (pos >= start) && (off < width);

  // first slot of the msb within each 32-bit half frame
  function [4:0] slot_start;
    input [1:0] f;
    begin
      case (f)
        `BRO_FMT_RJ16: slot_start = `BRO_START_RJ16; // see [R20] [R17]
        `BRO_FMT_RJ24: slot_start = `BRO_START_RJ24; // see [R20] [R17]
        `BRO_FMT_LJ24: slot_start = `BRO_START_LJ24; // see [R20] [R17]
        default: slot_start = `BRO_START_I2S24; // see [R20] [R17]
      endcase
    end
  endfunction

  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt <= `BRO_LAST_SLOT;
      cur_l <= 24'h00_0000;
      cur_r <= 24'h00_0000;
      word_clock_o <= 1'b0;
      data_o <= 1'b0;
    end else if (ce_i && bit_tick_i) begin
      cnt <= ncnt;
      cur_l <= nl;
      cur_r <= nr;
      // left half is high except in i2s, where it is low
      word_clock_o <= ncnt[5] ^ (fmt_i != `BRO_FMT_I2S24);
      data_o <= in_word & word[idx]; // see [R18]
    end
  end
endmodule

//--- bro_top.v
// output control of the biphase audio receiver: mode, lock, error, rate, serial data
// ----------------------------------------------------------------
// How it works
// [R1] parity error on pcm repeats the previous sample
// [R2] non-pcm data passes through despite parity errors
// [R3] sudden rate change forces the unlocked state
// [R4] rate measured on reference clock; none if absent
// [R5] unlocked or out of range gives code HL
// [R6] reference never seen since reset gives code LL
// [R7] stopped reference freezes estimate, resumes on return
// [R8] 32k is HH, 44.1k is LL, 48k is LH
// [R9] select low: recovered clocks, unlocked mutes outputs
// [R10] select high: reference clocks, data and status muted
// [R11] xti mode keeps flags, rate and pulse live
// [R12] no reference means no clocks in xti mode
// [R13] auto mode: board ties select to error output
// [R14] lock change pulse on every lock transition
// [R15] mode select never makes a lock change pulse
// [R16] reset while locked gives no lock change pulse
// [R17] format select picks rj16, rj24, lj24, i2s
// [R18] samples shift out msb first, two's complement
// [R19] error is unlock or parity, cleared at a word clock edge
// [R20] lj msb first slot, i2s one later, rj ends last
// ----------------------------------------------------------------
`timescale 1ns/1ns
`include "bro_map.vh"
module bro_top #(
  parameter REF_TIMEOUT = `BRO_REF_TIMEOUT
) (
  input wire sys_clk_i,
  input wire reset_i,
  input wire ce_i,
  input wire pll_locked_i,
  input wire clock_source_select_i,
  input wire reference_clock_in_i,
  input wire recovered_bit_clock_i,
  input wire recovered_sys_clock_i,
  input wire [1:0] output_format_select_i,
  input wire sample_valid_i,
  input wire sample_right_i,
  input wire [23:0] sample_data_i,
  input wire parity_error_i,
  input wire non_pcm_i,
  input wire channel_status_i,
  input wire block_start_i,
  input wire emphasis_i,
  output reg system_clock_out_o,
  output reg bit_clock_out_o,
  output reg word_clock_out_o,
  output reg serial_data_o,
  output reg channel_status_out_o,
  output reg block_start_flag_o,
  output reg audio_type_o,
  output reg emphasis_flag_o,
  output wire [1:0] rate_estimate_code_o,
  output reg lock_change_pulse_o,
  output reg error_o
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  reg [6:0] sync_a;
  reg [6:0] sync_b;
  wire [6:0] pins = {output_format_select_i, recovered_sys_clock_i, recovered_bit_clock_i,
                     reference_clock_in_i, clock_source_select_i, pll_locked_i};
  wire locked_pin = sync_b[0];
  wire xti_mode = sync_b[1];
  wire ref_lvl = sync_b[2];
  wire rbck_lvl = sync_b[3];
  wire rsck_lvl = sync_b[4];
  wire [1:0] fmt = sync_b[6:5];

  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sync_a <= 7'h00;
      sync_b <= 7'h00;
    end else if (ce_i) begin
      sync_a <= pins;
      sync_b <= sync_a;
    end
  end

  // ----------------------------------------------------------------
  // lock tracking and lock change pulse
  // ----------------------------------------------------------------
  reg lock_reg;
  reg [1:0] prime_cnt;
  wire rate_jump;
  wire locked_eff = locked_pin & ~rate_jump; // see [R3]

  // the pulse stays off until the lock synchroniser has filled and
  // lock_reg holds the pin's real level; otherwise a device that
  // comes out of reset already locked would show a false pulse
  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      lock_reg <= 1'b0;
      prime_cnt <= 2'h0;
      lock_change_pulse_o <= 1'b0;
    end else if (ce_i) begin
      lock_reg <= locked_eff;
      if (prime_cnt != `BRO_PRIME_EDGES) begin
        prime_cnt <= prime_cnt + 2'h1;
        lock_change_pulse_o <= 1'b0; // see [R16]
      end else begin
        lock_change_pulse_o <= lock_reg ^ locked_eff; // see [R14] [R15] [R11]
      end
    end
  end

  // ----------------------------------------------------------------
  // clock source selection
  // ----------------------------------------------------------------
  reg ref_prev;
  reg [1:0] xdiv;
  reg xbck;
  reg bck_prev;
  wire ref_edge = ref_lvl & ~ref_prev;
  wire src_bck = xti_mode ? xbck : rbck_lvl; // see [R9] [R10] [R13]
  wire bit_tick = bck_prev & ~src_bck;

  // the reference bit clock only advances on reference edges, so a
  // missing reference leaves every output clock standing still in xti mode
  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ref_prev <= 1'b0;
      xdiv <= 2'h0;
      xbck <= 1'b0;
      bck_prev <= 1'b0;
      bit_clock_out_o <= 1'b0;
      system_clock_out_o <= 1'b0;
    end else if (ce_i) begin
      ref_prev <= ref_lvl;
      bck_prev <= src_bck;
      if (ref_edge) begin // see [R12]
        if (xdiv == `BRO_XTI_BCK_HALF - 2'h1) begin
          xdiv <= 2'h0;
          xbck <= ~xbck;
        end else begin
          xdiv <= xdiv + 2'h1;
        end
      end
      bit_clock_out_o <= src_bck;
      system_clock_out_o <= xti_mode ? ref_lvl : rsck_lvl; // see [R10] [R9]
    end
  end

  // ----------------------------------------------------------------
  // parity concealment
  // ----------------------------------------------------------------
  reg [23:0] hold_l;
  reg [23:0] hold_r;
  wire par_evt = sample_valid_i & parity_error_i;
  wire conceal = par_evt & ~non_pcm_i;

  // repeating the last good word is the cheapest interpolation; it
  // costs no multiplier and is inaudible for isolated errors
  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      hold_l <= 24'h00_0000;
      hold_r <= 24'h00_0000;
    end else if (ce_i && sample_valid_i) begin
      if (conceal) begin
        hold_l <= hold_l; // see [R1]
        hold_r <= hold_r; // see [R1]
      end else if (sample_right_i) begin
        hold_r <= sample_data_i; // see [R2]
      end else begin
        hold_l <= sample_data_i; // see [R2]
      end
    end
  end

  // ----------------------------------------------------------------
  // serial data path and status gating
  // ----------------------------------------------------------------
  wire ser_wc;
  wire ser_d;
  wire mute = xti_mode | ~lock_reg;
  wire wc_edge = ser_wc ^ word_clock_out_o;

  bro_serializer u_ser (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .bit_tick_i(bit_tick),
    .fmt_i(fmt),
    .left_i(hold_l),
    .right_i(hold_r),
    .word_clock_o(ser_wc),
    .data_o(ser_d)
  );

  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      word_clock_out_o <= 1'b0;
      serial_data_o <= 1'b0;
      channel_status_out_o <= 1'b0;
      block_start_flag_o <= 1'b0;
      audio_type_o <= 1'b0;
      emphasis_flag_o <= 1'b0;
      error_o <= 1'b0;
    end else if (ce_i) begin
      word_clock_out_o <= ser_wc;
      serial_data_o <= ser_d & ~mute; // see [R9] [R10] [R13]
      channel_status_out_o <= channel_status_i & lock_reg & ~xti_mode; // see [R10] [R9]
      block_start_flag_o <= block_start_i & lock_reg; // see [R11] [R9]
      audio_type_o <= non_pcm_i & lock_reg; // see [R11] [R9]
      emphasis_flag_o <= emphasis_i & lock_reg; // see [R11] [R9]
      // a new fault wins over the clear at a word clock edge
      error_o <= ~locked_eff | par_evt | (error_o & ~wc_edge); // see [R19] [R13]
    end
  end

  // ----------------------------------------------------------------
  // rate estimator
  // ----------------------------------------------------------------
  bro_rate_est #(
    .TIMEOUT(REF_TIMEOUT)
  ) u_rate (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .ref_edge_i(ref_edge), // see [R4]
    .frame_tick_i(sample_valid_i & ~sample_right_i),
    .locked_i(lock_reg),
    .rate_code_o(rate_estimate_code_o),
    .rate_jump_o(rate_jump)
  );
endmodule

//--- bro_props.sv
// port checker for the receiver output block
`timescale 1ns/1ns
module bro_props (
  input wire sys_clk_i,
  input wire reset_i,
  input wire ce_i,
  input wire pll_locked_i,
  input wire clock_source_select_i,
  input wire recovered_sys_clock_i,
  input wire sample_valid_i,
  input wire parity_error_i,
  input wire block_start_i,
  input wire system_clock_out_o,
  input wire serial_data_o,
  input wire channel_status_out_o,
  input wire block_start_flag_o,
  input wire [1:0] rate_estimate_code_o,
  input wire lock_change_pulse_o,
  input wire error_o
);
  // ----------------------------------------------------------------
  // lock, error and muting relations
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);
  a_lock_pulse: assert property (
    $rose(pll_locked_i) && ce_i |-> ##[2:4] lock_change_pulse_o)
    else $error("lock gave no pulse");
  a_unlock_err: assert property (
    $fell(pll_locked_i) && ce_i |-> ##[2:4] (error_o && lock_change_pulse_o))
    else $error("unlock gave no error with pulse");
  a_reset_quiet: assert property (
    $fell(reset_i) |-> !lock_change_pulse_o [*5])
    else $error("pulse after reset");
  a_rate_reset: assert property (
    $fell(reset_i) |-> rate_estimate_code_o == 2'h0)
    else $error("rate code not low after reset");
  a_pll_mute: assert property (
    (!pll_locked_i) [*6] |-> !serial_data_o && !channel_status_out_o && !block_start_flag_o)
    else $error("unlocked outputs not muted");
  a_xti_mute: assert property (
    clock_source_select_i [*6] |-> !serial_data_o && !channel_status_out_o)
    else $error("xti mode outputs not muted");
  // status path waits for the synced and registered lock, hence the long run-in
  a_flag_live: assert property (
    (pll_locked_i && block_start_i) [*8] |-> block_start_flag_o)
    else $error("block start flag not passed");
  a_sck_pll: assert property (
    (pll_locked_i && !clock_source_select_i) [*8]
    |-> system_clock_out_o == $past(recovered_sys_clock_i, 3))
    else $error("system clock not from recovered clock");
  a_parity_err: assert property (
    sample_valid_i && parity_error_i && ce_i |-> ##[1:4] error_o)
    else $error("parity error not flagged");
  c_pulse: cover property (lock_change_pulse_o);
  c_xti: cover property (clock_source_select_i && block_start_flag_o);
  c_parity: cover property (sample_valid_i && parity_error_i);
endmodule
bind bro_top bro_props u_props (.sys_clk_i, .reset_i, .ce_i, .pll_locked_i,
  .clock_source_select_i, .recovered_sys_clock_i, .sample_valid_i, .parity_error_i,
  .block_start_i, .system_clock_out_o, .serial_data_o, .channel_status_out_o,
  .block_start_flag_o, .rate_estimate_code_o, .lock_change_pulse_o, .error_o);

//--- bro_sink.sv
// downstream sink model: collects each half of a frame from the serial line
`timescale 1ns/1ns
module bro_sink (
  input wire sys_clk_i,
  input wire reset_i,
  input wire bit_clock_i,
  input wire word_clock_i,
  input wire data_i,
  output reg [31:0] half_high_o,
  output reg [31:0] half_low_o
);
  reg bit_q;
  reg word_q;
  reg [31:0] shift;
  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      bit_q <= 1'b0;
      word_q <= 1'b0;
      shift <= 32'h0000_0000;
      half_high_o <= 32'h0000_0000;
      half_low_o <= 32'h0000_0000;
    end else begin
      bit_q <= bit_clock_i;
      word_q <= word_clock_i;
      // first slot ends in the top bit, so an msb-first word reads as is
      if (bit_clock_i && !bit_q)
        shift <= {shift[30:0], data_i};
      if (word_clock_i != word_q) begin
        if (word_q)
          half_high_o <= shift;
        else
          half_low_o <= shift;
      end
    end
  end
endmodule

//--- tb_top.sv
// self-checking bench for the receiver output block
`timescale 1ns/1ns
module tb_top;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg lock = 1'b0;
  reg sel = 1'b0;
  reg refc = 1'b0;
  reg ref_on = 1'b0;
  reg bck = 1'b0;
  reg sck = 1'b0;
  reg [1:0] fmt = 2'h0;
  reg val = 1'b0;
  reg rgt = 1'b0;
  reg [23:0] dat = 24'h00_0000;
  reg par = 1'b0;
  reg npcm = 1'b0;
  reg bst = 1'b1;
  reg emp = 1'b1;
  reg b0;
  wire sko, bco, wco, sdo, cso, bso, ato, eo, lp, err;
  wire [1:0] rate;
  wire [31:0] hi, lo;
  integer num_errors = 0;
  integer tests_run = 0;
  integer npulse = 0;
  integer f, k, n0;
  bro_top #(.REF_TIMEOUT(64)) dut_u (.sys_clk_i(clk), .reset_i(rst), .ce_i(1'b1),
    .pll_locked_i(lock), .clock_source_select_i(sel), .reference_clock_in_i(refc),
    .recovered_bit_clock_i(bck), .recovered_sys_clock_i(sck),
    .output_format_select_i(fmt), .sample_valid_i(val), .sample_right_i(rgt),
    .sample_data_i(dat), .parity_error_i(par), .non_pcm_i(npcm), .channel_status_i(1'b1),
    .block_start_i(bst), .emphasis_i(emp), .system_clock_out_o(sko), .bit_clock_out_o(bco),
    .word_clock_out_o(wco), .serial_data_o(sdo), .channel_status_out_o(cso),
    .block_start_flag_o(bso), .audio_type_o(ato), .emphasis_flag_o(eo),
    .rate_estimate_code_o(rate), .lock_change_pulse_o(lp), .error_o(err));
  bro_sink sink_u (.sys_clk_i(clk), .reset_i(rst), .bit_clock_i(bco), .word_clock_i(wco),
    .data_i(sdo), .half_high_o(hi), .half_low_o(lo));
  // ----------------------------------------------------------------
  // clocks: link bit clock and reference edges land on falling system edges, sck is offset
  // ----------------------------------------------------------------
  initial forever #50 clk = ~clk;
  initial forever #400 bck = ~bck;
  initial begin
    #37;
    forever #800 sck = ~sck;
  end
  initial forever begin
    #200;
    refc = ref_on & ~refc;
  end
  always @(posedge clk) if (lp === 1'b1) npulse <= npulse + 1;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task chk(input [31:0] got, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge clk);
  endtask
  task fin(input integer t);
    $display("test %0d done", t);
  endtask
  task send(input r, input [23:0] d, input p);
    begin
      val = 1'b1;
      rgt = r;
      dat = d;
      par = p;
      @(negedge clk);
      val = 1'b0;
      @(negedge clk);
    end
  endtask
  task wpulse(input integer n);
    integer i;
    begin
      for (i = 0; i < 30 && npulse < n; i = i + 1)
        @(negedge clk);
      chk(npulse, n);
      if (npulse < n)
        summarize;
    end
  endtask
  task summarize;
    begin
      $display("checks %0d errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // expected half-frame as the sink sees it, slot 0 in the top bit
  function [31:0] ex(input [1:0] m, input [23:0] d);
    case (m)
      2'h0: ex = {16'h0000, d[23:8]};
      2'h1: ex = {8'h00, d};
      2'h2: ex = {d, 8'h00};
      default: ex = {1'b0, d, 7'h00};
    endcase
  endfunction
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    cyc(6);
    rst = 1'b0;
    chk({sdo, cso, lp, err}, 4'h0);
    chk(rate, 2'h0);
    fin(1);
    // the lock synchroniser must fill before a lock change can pulse
    cyc(4);
    lock = 1'b1;
    wpulse(1);
    sel = 1'b1;
    cyc(12);
    chk({sko, bco}, 2'h0);
    sel = 1'b0;
    cyc(12);
    chk(npulse, 1);
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    cyc(12);
    chk(npulse, 1);
    fin(2);
    for (f = 0; f < 4; f = f + 1) begin
      fmt = f[1:0];
      send(1'b0, 24'h96_c35a, 1'b0);
      send(1'b1, 24'h3c_a5f1, 1'b0);
      cyc(1600);
      chk(f == 3 ? lo : hi, ex(f[1:0], 24'h96_c35a));
      chk(f == 3 ? hi : lo, ex(f[1:0], 24'h3c_a5f1));
    end
    chk({cso, bso, eo, ato}, 4'he);
    fin(3);
    send(1'b0, 24'h12_3456, 1'b1);
    send(1'b1, 24'h65_4321, 1'b1);
    chk(err, 1'b1);
    cyc(1600);
    chk(lo, ex(2'h3, 24'h96_c35a));
    npcm = 1'b1;
    send(1'b0, 24'h12_3456, 1'b1);
    send(1'b1, 24'h65_4321, 1'b1);
    cyc(1600);
    chk(lo, ex(2'h3, 24'h12_3456));
    chk(ato, 1'b1);
    npcm = 1'b0;
    fin(4);
    lock = 1'b0;
    wpulse(2);
    cyc(20);
    chk({err, sdo, cso, bso, eo}, 5'h10);
    chk(rate, 2'h0);
    fin(5);
    // jumps during the rate sweep unlock, so the status flag is kept low here
    bst = 1'b0;
    lock = 1'b1;
    wpulse(3);
    ref_on = 1'b1;
    n0 = npulse;
    for (f = 0; f < 4; f = f + 1) begin
      for (k = 0; k < 3; k = k + 1) begin
        send(1'b0, 24'h00_0000, 1'b0);
        cyc((f == 0 ? 3072 : f == 1 ? 2600 : f == 2 ? 2224 : 2048) - 2);
      end
      chk(rate, (8'h4b >> (2 * f)) & 8'h03);
    end
    chk(npulse > n0 + 5, 1'b1);
    fin(6);
    bst = 1'b1;
    sel = 1'b1;
    cyc(600);
    chk({sdo, cso, bso}, 3'h1);
    chk(rate, 2'h1);
    b0 = bco;
    cyc(8);
    chk(bco ^ b0, 1'b1);
    sel = 1'b0;
    ref_on = 1'b0;
    cyc(200);
    send(1'b0, 24'h00_0000, 1'b0);
    cyc(3000);
    send(1'b0, 24'h00_0000, 1'b0);
    cyc(10);
    chk(rate, 2'h1);
    fin(7);
    summarize;
  end
endmodule
